// ### include/bsdac_pkg.sv
package bsdac_pkg;
    // =====================================================
    // register map
    localparam logic [11:0] BSDAC_OFS_CTRL = 12'h000;
    localparam logic [11:0] BSDAC_OFS_CFG = 12'h004;
    localparam logic [11:0] BSDAC_OFS_STAT = 12'h008;
    localparam logic [11:0] BSDAC_OFS_RES = 12'h00c;
    // selectors: bit set = position installed; ff08 => upper 000000
    localparam logic [5:0] BSDAC_UPPER_RST = 6'h00;
    localparam logic [1:0] BSDAC_MIDDLE_RST = 2'h0;
    localparam logic [4:0] BSDAC_LOWER_RST = 5'h1e;
    localparam logic [2:0] BSDAC_BLOCK_BITS = 3'h7;
    // =====================================================
    // modes
    typedef enum logic [1:0] {BSDAC_BANK_IGNORE, BSDAC_BANK_LOW, BSDAC_BANK_HIGH} bsdac_bank_t;
    typedef enum logic [1:0] {BSDAC_IN_SE, BSDAC_IN_PSEUDO, BSDAC_IN_DIFF} bsdac_in_t;
    typedef enum logic [1:0] {BSDAC_FMT_BIN, BSDAC_FMT_OFS, BSDAC_FMT_TWOS} bsdac_fmt_t;
    typedef enum logic [2:0] {BSDAC_ST_15, BSDAC_ST_20, BSDAC_ST_30, BSDAC_ST_40,
        BSDAC_ST_85} bsdac_settle_t;
    // =====================================================
    // timing
    localparam int BSDAC_CLK_MHZ = 50;
    localparam int BSDAC_T15_US = 15;
    localparam int BSDAC_T20_US = 20;
    localparam int BSDAC_T30_US = 30;
    localparam int BSDAC_T40_US = 40;
    localparam int BSDAC_T85_US = 85;
    localparam logic [12:0] BSDAC_C15 = 13'(BSDAC_T15_US * BSDAC_CLK_MHZ);
    localparam logic [12:0] BSDAC_C20 = 13'(BSDAC_T20_US * BSDAC_CLK_MHZ);
    localparam logic [12:0] BSDAC_C30 = 13'(BSDAC_T30_US * BSDAC_CLK_MHZ);
    localparam logic [12:0] BSDAC_C40 = 13'(BSDAC_T40_US * BSDAC_CLK_MHZ);
    localparam logic [12:0] BSDAC_C85 = 13'(BSDAC_T85_US * BSDAC_CLK_MHZ);
    localparam logic [4:0] BSDAC_CH_SE = 5'h0f;
    localparam logic [4:0] BSDAC_CH_DIFF = 5'h07;
    localparam logic [4:0] BSDAC_CH_SE_X = 5'h1f;
    localparam logic [4:0] BSDAC_CH_DIFF_X = 5'h0f;
    // =====================================================
    // backplane cycle
    typedef struct packed {
        logic [15:0] addr;
        logic io_req;
        logic mem_req;
        logic ioexp;
        logic memex;
    } bsdac_bus_t;
endpackage

// ### rtl/bsdac_top.sv
`timescale 1ns/100ps
module bsdac_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // backplane cycle, asynchronous
    input wire bsdac_pkg::bsdac_bus_t bus_in,
    // conversion
    input wire logic [11:0] adc_code,
    output logic board_select,
    output logic [2:0] reg_index,
    output logic [4:0] mux_channel,
    output logic convert_start
);
    import bsdac_pkg::*;

    // =====================================================
    // configuration registers
    logic [5:0] upper_address_selector;
    logic [1:0] middle_address_selector;
    logic [4:0] lower_address_selector;
    logic address_space_selector; // 1 = memory
    bsdac_bank_t io_bank_option;
    bsdac_bank_t memory_bank_option;
    bsdac_in_t input_mode;
    logic input_range_selector; // 1 = bipolar
    bsdac_fmt_t output_format_selector;
    bsdac_settle_t settling_time_option;
    logic expansion;
    logic [11:0] result;
    logic [12:0] settle_cnt;
    logic settling;

    // =====================================================
    // pin synchroniser
    bsdac_bus_t bus_s1, bus_s2;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            bus_s1 <= '0;
            bus_s2 <= '0;
        end
        else
        begin
            bus_s1 <= bus_in;
            bus_s2 <= bus_s1;
        end

    function automatic logic bank_ok(input bsdac_bank_t opt, input logic lvl);
        bank_ok = (opt == BSDAC_BANK_IGNORE) || ((opt == BSDAC_BANK_LOW) && !lvl) ||
            ((opt == BSDAC_BANK_HIGH) && lvl);
    endfunction

    // =====================================================
    // address decode
    wire [12:0] want_hi = {~upper_address_selector, ~middle_address_selector,
        ~lower_address_selector};
    wire addr_hit = bus_s2.addr[15:3] == want_hi;
    wire io_hit = !address_space_selector && bus_s2.io_req &&
        bank_ok(io_bank_option, bus_s2.ioexp);
    wire mem_hit = address_space_selector && bus_s2.mem_req &&
        bank_ok(memory_bank_option, bus_s2.memex);
    wire next_select = addr_hit && (io_hit || mem_hit);

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            board_select <= 1'b0;
            reg_index <= 3'h0;
        end
        else
        begin
            board_select <= next_select;
            reg_index <= bus_s2.addr[2:0] & BSDAC_BLOCK_BITS;
        end

    // =====================================================
    // apb decode
    wire wr = psel && penable && pwrite;
    wire rd_ctrl = paddr == BSDAC_OFS_CTRL;
    wire rd_cfg = paddr == BSDAC_OFS_CFG;
    wire rd_stat = paddr == BSDAC_OFS_STAT;
    wire rd_res = paddr == BSDAC_OFS_RES;
    wire mapped = rd_ctrl || rd_cfg || rd_stat || rd_res;
    wire [4:0] ch_max = input_mode == BSDAC_IN_DIFF ?
        (expansion ? BSDAC_CH_DIFF_X : BSDAC_CH_DIFF) :
        (expansion ? BSDAC_CH_SE_X : BSDAC_CH_SE);
    wire [4:0] ch_req = pwdata[4:0] & ch_max;
    wire bad_pair = input_range_selector ? (output_format_selector == BSDAC_FMT_BIN) :
        (output_format_selector != BSDAC_FMT_BIN);
    wire [12:0] settle_len = settling_time_option == BSDAC_ST_20 ? BSDAC_C20 :
        settling_time_option == BSDAC_ST_30 ? BSDAC_C30 :
        settling_time_option == BSDAC_ST_40 ? BSDAC_C40 :
        settling_time_option == BSDAC_ST_85 ? BSDAC_C85 : BSDAC_C15;
    wire ch_write = wr && rd_ctrl;
    wire next_start = settling && settle_cnt == 13'h0001;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            upper_address_selector <= BSDAC_UPPER_RST;
            middle_address_selector <= BSDAC_MIDDLE_RST;
            lower_address_selector <= BSDAC_LOWER_RST;
            address_space_selector <= 1'b1;
            io_bank_option <= BSDAC_BANK_IGNORE;
            memory_bank_option <= BSDAC_BANK_IGNORE;
            input_mode <= BSDAC_IN_DIFF;
            input_range_selector <= 1'b1;
            output_format_selector <= BSDAC_FMT_TWOS;
            settling_time_option <= BSDAC_ST_15;
            expansion <= 1'b0;
        end
        else if (wr && rd_cfg)
        begin
            upper_address_selector <= pwdata[5:0];
            middle_address_selector <= pwdata[7:6];
            lower_address_selector <= pwdata[12:8];
            address_space_selector <= pwdata[13];
            io_bank_option <= bsdac_bank_t'(pwdata[15:14]);
            memory_bank_option <= bsdac_bank_t'(pwdata[17:16]);
            input_mode <= bsdac_in_t'(pwdata[19:18]);
            input_range_selector <= pwdata[20];
            output_format_selector <= bsdac_fmt_t'(pwdata[22:21]);
            settling_time_option <= bsdac_settle_t'(pwdata[25:23]);
            expansion <= pwdata[26];
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            mux_channel <= 5'h00;
            settling <= 1'b0;
            settle_cnt <= 13'h0000;
            convert_start <= 1'b0;
            result <= 12'h000;
        end
        else
        begin
            convert_start <= next_start;
            if (ch_write)
            begin
                mux_channel <= ch_req;
                settling <= 1'b1;
                settle_cnt <= settle_len;
            end
            else if (settling)
            begin
                settle_cnt <= settle_cnt - 13'h0001;
                settling <= settle_cnt != 13'h0001;
            end
            if (convert_start)
                result <= adc_code;
        end

    wire [31:0] cfg_word = {5'h00, expansion, settling_time_option, output_format_selector,
        input_range_selector, input_mode, memory_bank_option, io_bank_option,
        address_space_selector, lower_address_selector, middle_address_selector,
        upper_address_selector};
    wire [31:0] next_rdata = rd_ctrl ? {27'h0, mux_channel} : rd_cfg ? cfg_word :
        rd_stat ? {29'h0, bad_pair, board_select, settling} :
        rd_res ? {20'h0, result} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= next_rdata;
        end

    // =====================================================
    // checks
    a_select_addr: assert property (@(posedge pclk) disable iff (!presetn)
        board_select |-> $past(addr_hit)) else $error("select without address");
    a_select_type: assert property (@(posedge pclk) disable iff (!presetn)
        board_select |-> $past(io_hit || mem_hit)) else $error("select wrong type");
    a_io_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (addr_hit && !address_space_selector && bus_s2.io_req &&
        io_bank_option == BSDAC_BANK_IGNORE) |=> board_select) else $error("io ignore");
    a_mem_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (addr_hit && address_space_selector && bus_s2.mem_req &&
        memory_bank_option == BSDAC_BANK_IGNORE) |=> board_select) else $error("mem");
    a_io_bank: assert property (@(posedge pclk) disable iff (!presetn)
        (io_bank_option == BSDAC_BANK_LOW && bus_s2.ioexp && !address_space_selector)
        |=> !board_select) else $error("io bank");
    a_mem_bank: assert property (@(posedge pclk) disable iff (!presetn)
        (memory_bank_option == BSDAC_BANK_HIGH && !bus_s2.memex && address_space_selector)
        |=> !board_select) else $error("mem bank");
    a_diff_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (ch_write && input_mode == BSDAC_IN_DIFF && !expansion) |=>
        mux_channel <= BSDAC_CH_DIFF) else $error("diff chan");
    a_settle_15: assert property (@(posedge pclk) disable iff (!presetn)
        (ch_write && settling_time_option == BSDAC_ST_15) |=> !convert_start [*8])
        else $error("start early");
    a_settle_time: assert property (@(posedge pclk) disable iff (!presetn)
        (ch_write && settling_time_option == BSDAC_ST_15 && !settling) ##1
        (!ch_write [*8]) |-> settling) else $error("settle short");
    c_select: cover property (@(posedge pclk) disable iff (!presetn) $rose(board_select));
    c_start: cover property (@(posedge pclk) disable iff (!presetn) convert_start);
    c_bad: cover property (@(posedge pclk) disable iff (!presetn) bad_pair);
endmodule

// ### verif/bsdac_host_model.sv
`timescale 1ns/100ps
module bsdac_host_model
(
    // backplane levels seen by the card
    output bsdac_pkg::bsdac_bus_t bus_in
);
    import bsdac_pkg::*;
    // ==========================================
    // host cycle driver, called just after a clock edge
    initial bus_in = '0;
    task automatic start(input bsdac_bus_t c);
        bus_in <= c;
    endtask
    // released lines do not keep their last value
    task automatic stop();
        bus_in <= '{~bus_in.addr, 1'b0, 1'b0, ~bus_in.ioexp, ~bus_in.memex};
    endtask
endmodule

// ### verif/bus_slave_decode_and_adc_config_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module bus_slave_decode_and_adc_config_tb;
    import bsdac_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, board_select, convert_start, err_q;
    logic [11:0] paddr, adc_code;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] reg_index;
    logic [4:0] mux_channel;
    bsdac_bus_t bus_in;
    int errors = 0, n_tests = 0, cyc = 0, n;
    int us[5] = '{15, 20, 30, 40, 85};
    logic [1:0] md[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
    logic [4:0] mk[5] = '{5'h0f, 5'h0f, 5'h07, 5'h1f, 5'h0f};
    logic [31:0] pc[4] = '{32'h00400000, 32'h00500000, 32'h00000000, 32'h00100000};
    // ==========================================
    // clock and timeout
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            close_out();
        end
    end
    bsdac_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_in(bus_in), .adc_code(adc_code), .board_select(board_select),
        .reg_index(reg_index), .mux_channel(mux_channel), .convert_start(convert_start));
    bsdac_host_model u_host (.bus_in(bus_in));
    // ==========================================
    // tasks
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] cf(input logic [15:0] b, input logic sp,
        input logic [1:0] io, input logic [1:0] mb);
        return {14'h0, mb, io, sp, ~b[7:3], ~b[9:8], ~b[15:10]};
    endfunction
    // t is io_req, mem_req, ioexp, memex; all ones for c keeps the configuration
    task automatic dec(input logic [31:0] c, input logic [15:0] a, input logic [3:0] t,
        input logic e);
        if (c !== '1)
            apb(1'b1, BSDAC_OFS_CFG, c);
        u_host.start({a, t});
        repeat (5) @(posedge pclk);
        `CHK(board_select, e)
        if (e)
            `CHK(reg_index, a[2:0])
        u_host.stop();
        repeat (5) @(posedge pclk);
        `CHK(board_select, 1'b0)
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        adc_code = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, BSDAC_OFS_CFG, '0);
        `CHK(q, 32'h00583e00)
        dec('1, 16'hff0f, 4'b0101, 1'b1);
        dec(cf(16'h6130, 0, 0, 0), 16'h6130, 4'b1010, 1'b1);
        dec('1, 16'h6135, 4'b1000, 1'b1);
        dec('1, 16'h6138, 4'b1000, 1'b0);
        dec('1, 16'h7130, 4'b1000, 1'b0);
        dec('1, 16'h6130, 4'b0100, 1'b0);
        dec(cf(16'h6130, 0, 1, 0), 16'h6130, 4'b1010, 1'b0);
        dec('1, 16'h6130, 4'b1000, 1'b1);
        dec(cf(16'h6130, 0, 2, 0), 16'h6130, 4'b1010, 1'b1);
        dec(cf(16'hff08, 1, 0, 2), 16'hff08, 4'b0100, 1'b0);
        dec('1, 16'hff08, 4'b0101, 1'b1);
        dec(cf(16'hff08, 1, 0, 1), 16'hff08, 4'b0100, 1'b1);
        dec(cf(16'h0408, 1, 0, 0), 16'h0408, 4'b0101, 1'b1);
        dec('1, 16'h0008, 4'b0100, 1'b0);
        $display("test decode done");
        for (int k = 0; k < 5; k++)
        begin
            adc_code <= 12'h9a5 + 12'(k);
            apb(1'b1, BSDAC_OFS_CFG, (32'(k) << 23) | (32'(md[k]) << 18) | (32'(k > 2) << 26));
            if (k == 0)
            begin
                apb(1'b1, BSDAC_OFS_CTRL, 32'h1d);
                repeat (100) @(posedge pclk);
            end
            apb(1'b1, BSDAC_OFS_CTRL, 32'h1d);
            n = 1;
            #1;
            while (convert_start !== 1'b1 && n < 5000)
            begin
                @(posedge pclk);
                #1;
                n++;
            end
            `CHK(n, us[k] * BSDAC_CLK_MHZ)
            `CHK(mux_channel, 5'h1d & mk[k])
            @(posedge pclk);
            apb(1'b0, BSDAC_OFS_RES, '0);
            `CHK(q[11:0], 12'h9a5 + 12'(k))
        end
        $display("test settling done");
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, BSDAC_OFS_CFG, pc[k]);
            apb(1'b0, BSDAC_OFS_STAT, '0);
            `CHK(q[2], k == 0 || k == 3)
        end
        apb(1'b0, 12'h010, '0);
        `CHK({err_q, q}, 33'h100000000)
        $display("test format and unmapped done");
        close_out();
    end
endmodule
